// *** bwe_consts.svh ***
// Named offsets, field positions, reset values and bus codes of the write error status bank
`ifndef BWE_CONSTS_SVH
`define BWE_CONSTS_SVH

`define BWE_ADDR_BITS 10
`define BWE_OFS_CLEAR 10'h000
`define BWE_OFS_FLAGS 10'h004
`define BWE_OFS_REPEAT 10'h008
`define BWE_OFS_CFG1 10'h3F0
`define BWE_OFS_CFG2 10'h3F4
`define BWE_OFS_VERSION 10'h3F8
`define BWE_OFS_TYPE 10'h3FC
`define BWE_RESET_WORD 32'h00000000
`define BWE_ONE_WORD 32'h00000001
`define BWE_RESP_OKAY 2'h0
`define BWE_TRANS_ACTIVE_BIT 1
`define BWE_CFG1_SPLIT_BIT 2
`define BWE_CFG1_CLK_BIT 3
`define BWE_CFG1_MST_LSB 4
`define BWE_CFG1_MST_MSB 7
`define BWE_CFG2_MSB 19
`define BWE_MASTER_BITS 4
`define BWE_MAX_MASTERS 15

`endif

// *** bwe_master_model.sv ***
// Primary master model driving the local register slave port
`timescale 1ns/1ns
`default_nettype none
module bwe_master_model (
	input wire logic sys_clk, // System clock
	output var bwe_pkg::bwe_ahb_in_type ahb_in, // Request to the bank
	input wire bwe_pkg::bwe_ahb_out_type ahb_out // Answer from the bank
);
	initial ahb_in = '0;
	// ==========================================
	// One full 32-bit transfer, read data taken at the edge ending the data phase
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge sys_clk);
		ahb_in <= '{1'b1, {22'h0, a}, 2'h2, wr, 1'b1, ~wd};
		@(posedge sys_clk);
		ahb_in.sel_reg <= 1'b0;
		ahb_in.trans <= 2'h0;
		ahb_in.wdata <= wd;
		@(posedge sys_clk);
		while (!ahb_out.ready_resp) @(posedge sys_clk);
		rd = ahb_out.rdata;
		ahb_in.wdata <= ~wd;
	endtask
endmodule // bwe_master_model
`default_nettype wire

// *** bwe_pkg.sv ***
// Types shared by the write error status bank
`default_nettype none
package bwe_pkg;

	// Slave port request, sampled on sys_clk
	typedef struct packed {
		logic sel_reg;
		logic [31:0] addr;
		logic [1:0] trans;
		logic write;
		logic ready;
		logic [31:0] wdata;
	} bwe_ahb_in_type;

	// Slave port answer
	typedef struct packed {
		logic [31:0] rdata;
		logic ready_resp;
		logic [1:0] resp;
	} bwe_ahb_out_type;

	// Response seen by the outgoing master for one transfer
	typedef struct packed {
		logic error;
		logic write;
		logic [3:0] master;
	} bwe_err_type;

endpackage
`default_nettype wire

// *** bwe_status_bank.sv ***
// Write error status bank of the bridge with its local register slave port
`timescale 1ns/1ns
`default_nettype none
`include "bwe_consts.svh"

// What this block does
// - Interrupt is OR of all flag bits
// - Interrupt decoded combinationally, no output register
// - Write ERROR sets flag of originating master
// - Writing one to clear bit clears both
// - Per-master bits sit at positions one to N
// - Reserved bits read and reset as zero
// - Clear is write-only, flags are read-only
// - Flags are zero after reset
// - Flags may change between two reads
// - Decode clear, flags, repeat at 0,4,8
// - Read-only identity and configuration words at top
// - Error on already set flag sets repeat
module bwe_status_bank #(
	parameter int MASTERS = 4,
	parameter bit SPLIT_CAPABLE = 1'b0,
	parameter bit SYNC_CLOCK_MODE = 1'b1,
	parameter logic [19:0] CFG2_VALUE = 20'h00000,
	parameter logic [31:0] VERSION_ID = 32'h00000001, // Arbitrary value
	parameter logic [31:0] TYPE_ID = 32'h00000002 // Arbitrary value
) (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire bwe_pkg::bwe_ahb_in_type ahb_in, // Local register slave request
	output bwe_pkg::bwe_ahb_out_type ahb_out, // Local register slave answer
	input wire bwe_pkg::bwe_err_type err_in, // Outgoing master response
	output logic write_error_irq // Write error interrupt, active high
);

	// ==========================================================
	// Configuration
	localparam logic [31:0] FLAG_MASK = 32'(((64'h1 << (MASTERS + 1)) - 64'h1) & ~64'h1);
	localparam logic [3:0] MASTER_CODE = 4'(MASTERS);

	// Refuse counts that the four-bit master field cannot report
	if (MASTERS < 1 || MASTERS > `BWE_MAX_MASTERS) begin : g_bad_masters
		$error("MASTERS must lie between 1 and 15");
	end

	function automatic logic [31:0] cfg1_word();
		logic [31:0] w;
		w = `BWE_RESET_WORD;
		w[`BWE_CFG1_SPLIT_BIT] = SPLIT_CAPABLE;
		w[`BWE_CFG1_CLK_BIT] = SYNC_CLOCK_MODE;
		w[`BWE_CFG1_MST_MSB:`BWE_CFG1_MST_LSB] = MASTER_CODE;
		return w;
	endfunction

	// ==========================================================
	// Slave port state
	// A write waits here one cycle for its data phase; the read word is
	// registered and stands only in the data phase, zero otherwise
	logic wr_pending;
	logic [`BWE_ADDR_BITS-1:0] wr_addr;
	logic [31:0] rdata;
	logic next_wr_pending;
	logic [`BWE_ADDR_BITS-1:0] next_wr_addr;
	logic [31:0] next_rdata;
	logic [31:0] flags;
	logic [31:0] repeat_flags;
	logic acc_valid;
	logic rd_acc;
	logic [`BWE_ADDR_BITS-1:0] acc_addr;

	// Same clock for slave port and flags, so no crossing is needed
	always_comb begin
		acc_valid = ahb_in.sel_reg && ahb_in.trans[`BWE_TRANS_ACTIVE_BIT] && ahb_in.ready;
		acc_addr = ahb_in.addr[`BWE_ADDR_BITS-1:0];
		rd_acc = acc_valid && !ahb_in.write;
		next_wr_pending = acc_valid && ahb_in.write;
		next_wr_addr = acc_valid ? acc_addr : wr_addr;
		next_rdata = `BWE_RESET_WORD;
		if (rd_acc) begin
			unique case (acc_addr)
				`BWE_OFS_FLAGS: next_rdata = flags & FLAG_MASK;
				`BWE_OFS_REPEAT: next_rdata = repeat_flags & FLAG_MASK;
				`BWE_OFS_CFG1: next_rdata = cfg1_word();
				`BWE_OFS_CFG2: next_rdata = {12'h000, CFG2_VALUE};
				`BWE_OFS_VERSION: next_rdata = VERSION_ID;
				`BWE_OFS_TYPE: next_rdata = TYPE_ID;
				default: next_rdata = `BWE_RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_pending <= 1'b0;
			wr_addr <= `BWE_OFS_CLEAR;
			rdata <= `BWE_RESET_WORD;
		end else begin
			wr_pending <= next_wr_pending;
			wr_addr <= next_wr_addr;
			rdata <= next_rdata;
		end
	end

	// Always zero wait state, always OKAY; size and direction are not checked
	always_comb begin
		ahb_out.rdata = rdata;
		ahb_out.ready_resp = 1'b1;
		ahb_out.resp = `BWE_RESP_OKAY;
	end

	// ==========================================================
	// Error flags
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic [31:0] next_flags;
	logic [31:0] next_repeat_flags;

	always_comb begin
		set_vec = `BWE_RESET_WORD;
		if (err_in.error && err_in.write) begin
			set_vec = (`BWE_ONE_WORD << err_in.master) & FLAG_MASK;
		end
		clr_vec = `BWE_RESET_WORD;
		if (wr_pending && wr_addr == `BWE_OFS_CLEAR) begin
			clr_vec = ahb_in.wdata & FLAG_MASK;
		end
		// Set last so a simultaneous error survives the clear
		next_flags = (flags & ~clr_vec) | set_vec;
		next_repeat_flags = (repeat_flags & ~clr_vec) | (set_vec & flags);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags <= `BWE_RESET_WORD;
			repeat_flags <= `BWE_RESET_WORD;
		end else begin
			flags <= next_flags;
			repeat_flags <= next_repeat_flags;
		end
	end

	assign write_error_irq = |flags;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_irq_or_flags:
	assert property (write_error_irq == (flags != `BWE_RESET_WORD)) else $error("interrupt differs from OR of flags");

	a_error_sets_flag:
	assert property ((err_in.error && err_in.write && err_in.master >= 4'h1 && err_in.master <= MASTER_CODE)
		|=> flags[$past(err_in.master)]) else $error("write error did not set its flag");

	a_clear_drops_bits:
	assert property ((clr_vec != `BWE_RESET_WORD && set_vec == `BWE_RESET_WORD)
		|=> ((flags | repeat_flags) & $past(clr_vec)) == `BWE_RESET_WORD) else $error("clear left bits set");

	a_reserved_zero:
	assert property (((flags | repeat_flags) & ~FLAG_MASK) == `BWE_RESET_WORD) else $error("reserved bit set");

	a_flags_stable:
	assert property ((set_vec == `BWE_RESET_WORD && clr_vec == `BWE_RESET_WORD) |=> $stable(flags))
		else $error("flags changed without cause");

	a_flags_after_reset:
	assert property ($past(rst) |-> flags == `BWE_RESET_WORD && !write_error_irq) else $error("flags not zero after reset");

	a_repeat_set:
	assert property (((set_vec & flags) != `BWE_RESET_WORD) |=> ((repeat_flags & $past(set_vec)) == $past(set_vec)))
		else $error("repeat flag not set");

	a_read_flags:
	assert property ((rd_acc && acc_addr == `BWE_OFS_FLAGS) |=> ahb_out.rdata == $past(flags)) else $error("bad flags read");

	a_read_clear_zero:
	assert property ((rd_acc && acc_addr == `BWE_OFS_CLEAR) |=> ahb_out.rdata == `BWE_RESET_WORD) else $error("clear read not zero");

	a_read_type:
	assert property ((rd_acc && acc_addr == `BWE_OFS_TYPE) |=> ahb_out.rdata == TYPE_ID) else $error("bad type read");

	a_answer_okay:
	assert property (ahb_out.ready_resp && ahb_out.resp == `BWE_RESP_OKAY) else $error("answer not zero wait OKAY");

	// Set against clear in one cycle, and the clear of only the given bits
	a_set_beats_clear:
	assert property (((set_vec & clr_vec) != `BWE_RESET_WORD)
		|=> ((flags & $past(set_vec)) == $past(set_vec)))
		else $error("clear won over a new error");

	a_clear_keeps_rest:
	assert property ((clr_vec != `BWE_RESET_WORD && set_vec == `BWE_RESET_WORD)
		|=> flags == ($past(flags) & ~$past(clr_vec)))
		else $error("clear touched bits it was not given");

	a_repeat_needs_flag:
	assert property ((repeat_flags & ~flags) == `BWE_RESET_WORD)
		else $error("repeat flag without its flag");

	a_irq_after_error:
	assert property ((err_in.error && err_in.write && err_in.master >= 4'h1 && err_in.master <= MASTER_CODE)
		|=> write_error_irq)
		else $error("interrupt missing after write error");

	// What a read returns in its data phase
	a_read_repeat:
	assert property ((rd_acc && acc_addr == `BWE_OFS_REPEAT) |=> ahb_out.rdata == $past(repeat_flags))
		else $error("bad repeat read");

	a_read_cfg1:
	assert property ((rd_acc && acc_addr == `BWE_OFS_CFG1) |=> ahb_out.rdata == cfg1_word())
		else $error("bad first configuration read");

	a_read_cfg2:
	assert property ((rd_acc && acc_addr == `BWE_OFS_CFG2) |=> ahb_out.rdata == {12'h000, CFG2_VALUE})
		else $error("bad second configuration read");

	a_read_version:
	assert property ((rd_acc && acc_addr == `BWE_OFS_VERSION) |=> ahb_out.rdata == VERSION_ID)
		else $error("bad version read");

	a_rdata_idle_zero:
	assert property (!rd_acc |=> ahb_out.rdata == `BWE_RESET_WORD)
		else $error("read data left standing");

endmodule // bwe_status_bank
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench of the write error status bank
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	bwe_pkg::bwe_ahb_in_type ahb_in;
	bwe_pkg::bwe_ahb_out_type ahb_out;
	bwe_pkg::bwe_err_type err_in = '0;
	logic write_error_irq;
	logic [31:0] exp_f = '0, exp_r = '0, d, m;
	logic [3:0] k;
	int fails = 0, checks_done = 0, cycles = 0, i;
	integer seed = 32'hD9F51AB0;
	bwe_status_bank u_dut (.sys_clk(sys_clk), .rst(rst), .ahb_in(ahb_in), .ahb_out(ahb_out),
		.err_in(err_in), .write_error_irq(write_error_irq));
	bwe_master_model u_mst (.sys_clk(sys_clk), .ahb_in(ahb_in), .ahb_out(ahb_out));
	initial forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			test_done();
		end
	end
	// ==========================================
	// Expectation and comparison helpers
	function automatic logic [31:0] hit(input logic [3:0] kk);
		return (kk >= 4'h1 && kk <= 4'h4) ? 32'h1 << kk : 32'h0;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
		u_mst.xfer(1'b0, a, 32'h0, d);
		chk(d, exp);
	endtask
	task automatic test_done();
		if (fails == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk(10'h004, 32'h0);
		rd_chk(10'h008, 32'h0);
		rd_chk(10'h000, 32'h0);
		rd_chk(10'h3F0, 32'h00000048);
		rd_chk(10'h3F4, 32'h0);
		rd_chk(10'h3F8, 32'h1);
		rd_chk(10'h3FC, 32'h2);
		rd_chk(10'h100, 32'h0);
		for (i = 0; i < 200; i++) begin
			k = {1'b0, 3'($random(seed))};
			m = $random(seed);
			@(posedge sys_clk);
			err_in <= '{1'b1, m[0] | m[1], k};
			@(posedge sys_clk);
			err_in <= '{1'b0, m[2], ~k};
			if (m[0] | m[1]) begin
				exp_r |= exp_f & hit(k);
				exp_f |= hit(k);
			end
			if (m[5:4] == 2'h0) begin
				u_mst.xfer(1'b1, 10'h000, m, d);
				exp_f &= ~m;
				exp_r &= ~m;
			end
			if (m[7:6] == 2'h0) u_mst.xfer(1'b1, 10'h004, m, d);
			rd_chk(10'h004, exp_f);
			rd_chk(10'h008, exp_r);
			chk({31'h0, write_error_irq}, {31'h0, exp_f != 32'h0});
		end
		// Error and clear meet in one cycle, then a reset in mid-run
		exp_r = (exp_r & ~32'h0000001E) | (exp_f & hit(4'h2));
		exp_f = (exp_f & ~32'h0000001E) | hit(4'h2);
		fork
			u_mst.xfer(1'b1, 10'h000, 32'h0000001E, d);
			begin
				repeat (2) @(posedge sys_clk);
				err_in <= '{1'b1, 1'b1, 4'h2};
				@(posedge sys_clk);
				err_in <= '0;
			end
		join
		rd_chk(10'h004, exp_f);
		rd_chk(10'h008, exp_r);
		chk({31'h0, write_error_irq}, 32'h00000001);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk(10'h004, 32'h0);
		rd_chk(10'h008, 32'h0);
		chk({31'h0, write_error_irq}, 32'h0);
		test_done();
	end
endmodule // tb
`default_nettype wire
